//--- verilog/bpo_port.sv
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ps
// Overview of operation
// - force zero low zeroes whole bus
// - position reset loads zero or offset
// - hold high freezes four position registers
// - async hold pin resynchronised drives hold
// - divide-by-n releases hold one period
// - outside fast mode, bus enabled only on address match
// - outside fast mode, read enable low drives, high floats
// - error pin gated only in 3-state
// - address match selects driven error axis
// - async hold stable within 100 ns
// - clock modes drive strobe, capture rising
// - fast mode ten bits per 100 ns
// - setup bit d4 enables all fast outputs
// - fast mode blocks addressed 36-bit read
// - fast outputs off after power-up
// - fault is or of masked status
// - fault holds until status cleared
// - compare outputs active high, 10 MHz
// - enabled axis clear loads preset or zero
// - read drives only matching axis register
module bpo_port (
   input  wire logic                   clk_sys,             // 100 MHz clock
   input  wire logic                   nrst,                // async reset, low
   input  wire logic                   ce,                  // clock enable
   input  wire logic                   psel,                // apb select
   input  wire logic                   penable,             // apb enable
   input  wire logic                   pwrite,              // apb direction
   input  wire logic [11:0]            paddr,               // apb byte address
   input  wire logic [31:0]            pwdata,              // apb write data
   output logic [31:0]                 prdata,              // apb read data
   output logic                        pready,              // apb ready
   output logic                        pslverr,             // apb error
   input  wire logic                   force_zero_n,        // force zero pin
   input  wire logic                   pos_reset_n,         // position reset pin
   input  wire logic                   hold_pin_in,         // output hold pin in
   output logic                        hold_pin_out,        // output hold pin out
   output logic                        hold_pin_oe,         // output hold enable
   input  wire logic                   read_n,              // read enable pin
   input  wire logic [5:0]             port_select_address, // select address pins
   input  wire logic [3:0]             axis_clear_input_n,  // per-axis clear pins
   input  wire logic                   hold_or_strobe_pin_in,  // strobe pin in
   output logic                        hold_or_strobe_pin_out, // strobe pin out
   output logic                        hold_or_strobe_pin_oe,  // strobe pin enable
   input  wire bpo_pkg::bpo_pos_t      pos_in,              // live counters
   input  wire bpo_pkg::bpo_pos_t      cmp_high,            // high limits
   input  wire bpo_pkg::bpo_pos_t      cmp_low,             // low limits
   input  wire logic [31:0]            err_status,          // board error status
   input  wire bpo_pkg::bpo_mask_t     err_mask,            // per-axis masks
   output logic [35:0]                 position_output_bus, // position bus out
   output logic [35:0]                 position_output_oe,  // per-bit enable
   output bpo_pkg::bpo_fast_t          fast_output_bit,     // fast bits, all four axes
   output logic                        error_pin_out,       // error pin level
   output logic                        error_pin_oe,        // error pin enable
   output logic [3:0]                  axis_fault_output,   // per-axis faults
   output logic [3:0]                  axis_compare_output, // per-axis compare
   output logic [3:0]                  pos_load,            // counter load request
   output logic [3:0]                  pos_load_preset      // load offset not zero
);
   // ***************************************************
   // state
   // ***************************************************
   typedef struct packed {
      logic [bpo_pkg::PIN_W-1:0] s1;        // sync stage one
      logic [bpo_pkg::PIN_W-1:0] s2;        // sync stage two
      logic [bpo_pkg::PIN_W-1:0] s3;        // sync stage three
      logic [bpo_pkg::PIN_W-1:0] flt;       // agreed pin levels
      logic [31:0]               out_ctrl;  // output control
      logic [15:0]               setup;     // axis setup
      logic [5:0]                divn;      // n minus one
      logic [7:0]                cmp_mode;  // comparator modes
      logic [31:0]               prdata;    // read data
      logic                      pready;    // ready
      logic                      pslverr;   // error
      logic [3:0]                phase;     // phase within tick
      logic [5:0]                div_cnt;   // periods to next unload
      logic                      last_cap;  // capture at last tick
      bpo_pkg::bpo_pos_t         hp;        // hardware position registers
      logic [35:0]               bus;       // bus data
      logic [35:0]               bus_oe;    // bus enables
      bpo_pkg::bpo_fast_t        fast;      // fast bits
      logic [3:0]                fault;     // fault outputs
      logic                      err_out;   // error pin level
      logic                      err_oe;    // error pin enable
      logic [3:0]                cmp;       // compare outputs
      logic                      hold_out;  // hold pin level
      logic                      hold_oe;   // hold pin enable
      logic                      stb_out;   // strobe pin level
      logic                      stb_oe;    // strobe pin enable
      logic [3:0]                load;      // load requests
      logic [3:0]                load_pre;  // preset flags
   } bpo_state_t;

   bpo_state_t q;       // registered state
   bpo_state_t next_q;  // next state

   // ***************************************************
   // decoded controls
   // ***************************************************
   logic                 tick;      // last phase of 10 MHz period
   logic                 hold;      // position registers frozen
   logic                 fast_en;   // fast parallel mode
   logic [3:0]           match;     // address match per axis
   logic [1:0]           sel;       // lowest matching axis
   logic                 any_match; // some axis matches
   logic [3:0]           fault_c;   // combined masked faults
   bpo_pkg::bpo_hold_t   hmode;     // hold mode
   bpo_pkg::bpo_err_t    emode;     // error mode
   logic [bpo_pkg::PIN_W-1:0] pins; // raw pin vector

   assign pins = {hold_or_strobe_pin_in, axis_clear_input_n, port_select_address,
                  read_n, hold_pin_in, pos_reset_n, force_zero_n};
   assign tick = (q.phase == bpo_pkg::TICK_LAST);
   assign fast_en = q.setup[bpo_pkg::SU_FAST_EN];
   assign hmode = bpo_pkg::bpo_hold_t'(q.out_ctrl[bpo_pkg::OC_HOLD_MODE +: 2]);
   assign emode = bpo_pkg::bpo_err_t'(q.out_ctrl[bpo_pkg::OC_ERR_MODE +: 2]);

   // hold source per mode
   always_comb begin
      unique case (hmode)
         // held a few system clocks after rise
         bpo_pkg::BPO_HOLD_ASYNC: hold = q.flt[bpo_pkg::PIN_AOH];
         bpo_pkg::BPO_HOLD_DIVN:  hold = (q.div_cnt != 6'h00);
         bpo_pkg::BPO_HOLD_SLAVE: hold = q.flt[bpo_pkg::PIN_HOLD];
         bpo_pkg::BPO_HOLD_PIN:   hold = q.flt[bpo_pkg::PIN_HOLD];
      endcase
   end

   // address match and fault combine per axis
   always_comb begin
      sel = 2'h0;
      any_match = 1'b0;
      for (int i = bpo_pkg::AXES - 1; i >= 0; i--) begin
         match[i] = (q.flt[bpo_pkg::PIN_ADDR +: bpo_pkg::ADDR_W]
                     == q.out_ctrl[i*bpo_pkg::ADDR_W +: bpo_pkg::ADDR_W]);
         if (match[i]) begin
            sel = 2'(i);
            any_match = 1'b1;
         end
         fault_c[i] = |(err_status & err_mask[i]);
      end
   end

   // ***************************************************
   // next state
   // ***************************************************
   always_comb begin
      next_q = q;
      // three flops, accept when two and three agree
      next_q.s1 = pins;
      next_q.s2 = q.s1;
      next_q.s3 = q.s2;
      next_q.flt = (q.s2 & ~(q.s2 ^ q.s3)) | (q.flt & (q.s2 ^ q.s3));

      // apb: answer in the first access cycle
      next_q.pready = 1'b0;
      next_q.pslverr = 1'b0;
      if (psel && !penable) begin
         next_q.pready = 1'b1;
         next_q.prdata = 32'h0000_0000;
         unique case (paddr)
            bpo_pkg::OFS_OUT_CTRL: next_q.prdata = q.out_ctrl;
            bpo_pkg::OFS_SETUP:    next_q.prdata = {16'h0000, q.setup};
            bpo_pkg::OFS_DIVN:     next_q.prdata = {26'h0, q.divn};
            bpo_pkg::OFS_CMP:      next_q.prdata = {24'h0, q.cmp_mode};
            bpo_pkg::OFS_STATUS:   next_q.prdata = {8'h00, q.cmp, q.fault,
                                                    hold, q.flt};
            default:               next_q.pslverr = 1'b1; // unmapped
         endcase
      end
      if (psel && penable && q.pready && pwrite && !q.pslverr) begin
         unique case (paddr)
            bpo_pkg::OFS_OUT_CTRL: next_q.out_ctrl = pwdata;
            bpo_pkg::OFS_SETUP:    next_q.setup = pwdata[15:0];
            bpo_pkg::OFS_DIVN:     next_q.divn = pwdata[5:0];
            bpo_pkg::OFS_CMP:      next_q.cmp_mode = pwdata[7:0];
            default:               next_q.pslverr = 1'b0; // status is read-only
         endcase
      end

      // 10 MHz timebase from the system clock
      next_q.phase = tick ? 4'h0 : q.phase + 4'h1;
      if (tick) begin
         // n periods, n from 1 to 64
         next_q.div_cnt = (q.div_cnt == 6'h00) ? q.divn : q.div_cnt - 6'h01;
         next_q.last_cap = !hold;
         if (!hold) begin
            next_q.hp = pos_in;
         end
         // compare refreshed each 10 MHz period
         for (int i = 0; i < bpo_pkg::AXES; i++) begin
            unique case (q.cmp_mode[2*i +: 2])
               2'b00: next_q.cmp[i] = 1'b0;
               2'b01: next_q.cmp[i] = (pos_in[i] > cmp_high[i]);
               2'b10: next_q.cmp[i] = (pos_in[i] < cmp_low[i]);
               2'b11: next_q.cmp[i] = (pos_in[i] > cmp_high[i])
                                      || (pos_in[i] < cmp_low[i]);
            endcase
         end
      end

      // hold pin driven in async and master modes
      next_q.hold_out = hold;
      next_q.hold_oe = (hmode == bpo_pkg::BPO_HOLD_ASYNC)
                       || (hmode == bpo_pkg::BPO_HOLD_DIVN);
      // clock rises mid-period after a capture
      next_q.stb_oe = (hmode == bpo_pkg::BPO_HOLD_DIVN)
                      || (hmode == bpo_pkg::BPO_HOLD_SLAVE);
      next_q.stb_out = next_q.stb_oe && q.last_cap
                       && (q.phase >= bpo_pkg::STROBE_ON)
                       && (q.phase < bpo_pkg::STROBE_OFF);

      // position bus
      next_q.bus = 36'h0;
      next_q.bus_oe = 36'h0;
      if (fast_en) begin
         // shared pins carry axis one fast bits only
         next_q.bus[bpo_pkg::FAST_W-1:0] = q.hp[0][bpo_pkg::FAST_W-1:0];
         next_q.bus_oe[bpo_pkg::FAST_W-1:0] = {bpo_pkg::FAST_W{1'b1}};
      end else if (any_match && !q.flt[bpo_pkg::PIN_RD]) begin
         // drive only while read enable low
         // data from the matching axis register
         next_q.bus = q.hp[sel];
         next_q.bus_oe = {36{1'b1}};
      end
      if (!q.flt[bpo_pkg::PIN_FZ]) begin
         next_q.bus = 36'h0;
      end
      // ten bits per axis, 100 ns cadence
      for (int i = 0; i < bpo_pkg::AXES; i++) begin
         next_q.fast[i] = fast_en ? q.hp[i][bpo_pkg::FAST_W-1:0] : 10'h000;
      end

      // status stays sticky upstream, so faults track it
      next_q.fault = fault_c;
      // error pin shows the matched axis
      next_q.err_out = any_match && q.fault[sel];
      unique case (emode)
         bpo_pkg::BPO_ERR_TTL: next_q.err_oe = 1'b1;
         bpo_pkg::BPO_ERR_OC: begin
            // pull low when clear, release when faulty
            next_q.err_oe = !next_q.err_out;
            next_q.err_out = 1'b0;
         end
         bpo_pkg::BPO_ERR_TRI,
         bpo_pkg::BPO_ERR_TRI2: next_q.err_oe = any_match
                                                && !q.flt[bpo_pkg::PIN_RD];
      endcase

      // counter loads, level requests while pins are low
      for (int i = 0; i < bpo_pkg::AXES; i++) begin
         // axis clear needs its enable bit
         next_q.load[i] = !q.flt[bpo_pkg::PIN_PR]
                          || (q.setup[bpo_pkg::SU_RST_EN + i]
                              && !q.flt[bpo_pkg::PIN_CLR + i]);
         next_q.load_pre[i] = next_q.load[i] && q.setup[bpo_pkg::SU_PRESET + i];
      end
   end

   // ***************************************************
   // registers
   // ***************************************************
   // pins reset to inactive so nothing fires on release
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         q <= '0;
         q.s1 <= bpo_pkg::PIN_IDLE;
         q.s2 <= bpo_pkg::PIN_IDLE;
         q.s3 <= bpo_pkg::PIN_IDLE;
         q.flt <= bpo_pkg::PIN_IDLE;
         q.out_ctrl <= bpo_pkg::OUT_CTRL_RST;
         q.setup <= bpo_pkg::SETUP_RST;
         q.divn <= bpo_pkg::DIVN_RST;
         q.cmp_mode <= bpo_pkg::CMP_RST;
      end else if (ce) begin
         q <= next_q;
      end
   end

   assign prdata = q.prdata;
   assign pready = q.pready;
   assign pslverr = q.pslverr;
   assign hold_pin_out = q.hold_out;
   assign hold_pin_oe = q.hold_oe;
   assign hold_or_strobe_pin_out = q.stb_out;
   assign hold_or_strobe_pin_oe = q.stb_oe;
   assign position_output_bus = q.bus;
   assign position_output_oe = q.bus_oe;
   assign fast_output_bit = q.fast;
   assign error_pin_out = q.err_out;
   assign error_pin_oe = q.err_oe;
   assign axis_fault_output = q.fault;
   assign axis_compare_output = q.cmp;
   assign pos_load = q.load;
   assign pos_load_preset = q.load_pre;

   // ***************************************************
   // checks
   // ***************************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);

   force_zero_a: assert property (ce && !q.flt[bpo_pkg::PIN_FZ] |=> q.bus == 36'h0)
      else $error("bus not zero under force zero");
   pos_reset_a: assert property (ce && !q.flt[bpo_pkg::PIN_PR] |=> q.load == 4'hF)
      else $error("position reset did not load all axes");
   hold_freeze_a: assert property (ce && hold |=> q.hp == $past(q.hp))
      else $error("held position register changed");
   read_float_a: assert property (ce && q.flt[bpo_pkg::PIN_RD] && !fast_en
                                  |=> q.bus_oe == 36'h0)
      else $error("bus driven with read enable high");
   addr_match_a: assert property (ce && !any_match && !fast_en
                                  |=> q.bus_oe == 36'h0)
      else $error("bus driven without address match");
   fast_idle_a: assert property (ce && !fast_en |=> q.fast == '0)
      else $error("fast outputs driven while disabled");
   fast_block_a: assert property (ce && fast_en |=> q.bus_oe[35:10] == 26'h0)
      else $error("addressed read during fast mode");
   err_gate_a: assert property (ce && emode == bpo_pkg::BPO_ERR_TRI
                                && q.flt[bpo_pkg::PIN_RD] |=> !q.err_oe)
      else $error("3-state error pin driven without read");
   fault_or_a: assert property (ce
                                |=> q.fault[0] == |($past(err_status) & $past(err_mask[0])))
      else $error("axis fault differs from masked status");
   clear_gate_a: assert property (ce && !q.setup[bpo_pkg::SU_RST_EN]
                                  && q.flt[bpo_pkg::PIN_PR] |=> !q.load[0])
      else $error("disabled axis clear loaded counter");
   async_hold_a: assert property (ce && hmode == bpo_pkg::BPO_HOLD_ASYNC
                                  && q.flt[bpo_pkg::PIN_AOH] |=> q.hp == $past(q.hp))
      else $error("async hold did not freeze registers");
endmodule

//--- verilog/bpo_pkg.sv
package bpo_pkg;
   // ***************************************************
   // timing
   // ***************************************************
   localparam int SYS_PERIOD_NS = 10;                       // system clock period
   localparam int TICK_PERIOD_NS = 100;                     // board 10 MHz period
   localparam int TICK_DIV = TICK_PERIOD_NS / SYS_PERIOD_NS; // sys cycles per tick
   localparam logic [3:0] TICK_LAST = 4'(TICK_DIV - 1);     // last phase of a tick
   localparam logic [3:0] STROBE_ON = 4'h4;                 // output clock rise phase
   localparam logic [3:0] STROBE_OFF = 4'h9;                // output clock fall phase
   // ***************************************************
   // geometry
   // ***************************************************
   localparam int AXES = 4;        // axis count
   localparam int POS_W = 36;      // position word width
   localparam int FAST_W = 10;     // fast parallel bits per axis
   localparam int ADDR_W = 6;      // select address width
   localparam int PIN_W = 15;      // synchronised pin vector width
   // ***************************************************
   // synchronised pin vector positions
   // ***************************************************
   localparam int PIN_FZ = 0;      // force zero, active low
   localparam int PIN_PR = 1;      // position reset, active low
   localparam int PIN_HOLD = 2;    // output hold pin, active high
   localparam int PIN_RD = 3;      // read enable, active low
   localparam int PIN_ADDR = 4;    // select address lsb
   localparam int PIN_CLR = 10;    // axis clear inputs lsb, active low
   localparam int PIN_AOH = 14;    // hold or strobe pin input
   localparam logic [PIN_W-1:0] PIN_IDLE = 15'h3FFB; // idle levels: hold and aoh low, rest high
   // ***************************************************
   // apb register offsets
   // ***************************************************
   localparam logic [11:0] OFS_OUT_CTRL = 12'h000; // output control
   localparam logic [11:0] OFS_SETUP = 12'h004;    // axis setup
   localparam logic [11:0] OFS_DIVN = 12'h008;     // divide-by-n value minus one
   localparam logic [11:0] OFS_CMP = 12'h00C;      // comparator modes
   localparam logic [11:0] OFS_STATUS = 12'h010;   // read-only state
   // ***************************************************
   // field positions
   // ***************************************************
   localparam int OC_ERR_MODE = 24;  // output control: error mode, 2 bits
   localparam int OC_HOLD_MODE = 26; // output control: hold mode, 2 bits
   localparam int SU_FAST_EN = 4;    // setup: fast output enable (d4)
   localparam int SU_RST_EN = 8;     // setup: axis clear enables, 4 bits
   localparam int SU_PRESET = 12;    // setup: preset enables, 4 bits
   localparam logic [31:0] OUT_CTRL_RST = 32'h0000_0000; // reset values
   localparam logic [15:0] SETUP_RST = 16'h0000;
   localparam logic [5:0] DIVN_RST = 6'h00;
   localparam logic [7:0] CMP_RST = 8'h00;
   // ***************************************************
   // modes and carriers
   // ***************************************************
   typedef enum logic [1:0] {
      BPO_HOLD_PIN = 2'b00,    // hold from output hold pin
      BPO_HOLD_ASYNC = 2'b01,  // hold from hold or strobe pin
      BPO_HOLD_DIVN = 2'b10,   // divide-by-n master, clock out
      BPO_HOLD_SLAVE = 2'b11   // hold pin slave, clock out
   } bpo_hold_t;
   typedef enum logic [1:0] {
      BPO_ERR_TTL = 2'b00,     // always driven
      BPO_ERR_OC = 2'b01,      // open collector
      BPO_ERR_TRI = 2'b10,     // 3-state by read enable
      BPO_ERR_TRI2 = 2'b11     // same as 3-state
   } bpo_err_t;
   typedef logic [AXES-1:0][POS_W-1:0] bpo_pos_t;   // four position words
   typedef logic [AXES-1:0][31:0] bpo_mask_t;       // four error masks
   typedef logic [AXES-1:0][FAST_W-1:0] bpo_fast_t; // fast bits per axis
endpackage

//--- bench/bpo_user_hw.sv
`timescale 1ns/1ps
// user logic on the backplane: floating bits read as noise, latch on strobe rise
module bpo_user_hw (
   input  wire logic        clk_sys, // system clock
   input  wire logic        strobe,  // strobe wire level
   input  wire logic [35:0] bus,     // bus drive values
   input  wire logic [35:0] oe,      // bus drive enables
   output logic [35:0]      lvl,     // resolved wire level
   output logic [35:0]      latched  // captured word
);
   logic [35:0] last = 36'h0; // undriven bits flip every cycle
   assign lvl = (bus & oe) | (~last & ~oe);
   always @(posedge clk_sys) last <= lvl;
   always @(posedge strobe) latched <= lvl;
endmodule

//--- bench/bpo_port_tb.sv
`timescale 1ns/1ps
module bpo_port_tb;
   logic clk_sys = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, err_status = 32'h0, rd;
   logic force_zero_n = 1, pos_reset_n = 1, read_n = 1, aoh_drv = 0, aoh_run = 0, aoh_hi = 0;
   logic hold_pin_in, hold_pin_out, hold_pin_oe, error_pin_out, error_pin_oe;
   logic hold_or_strobe_pin_in, hold_or_strobe_pin_out, hold_or_strobe_pin_oe;
   logic [5:0] port_select_address = 6'h00;
   logic [3:0] axis_clear_input_n = 4'hF, axis_fault_output, axis_compare_output;
   logic [3:0] pos_load, pos_load_preset;
   logic [35:0] position_output_bus, position_output_oe, lvl, latched;
   bpo_pkg::bpo_pos_t pos_in, org, cmp_high = '0, cmp_low = '0;
   bpo_pkg::bpo_mask_t err_mask = '0;
   bpo_pkg::bpo_fast_t fast_output_bit, fexp;
   int failures = 0, comparisons = 0, n;
   localparam logic [31:0] OC = 32'h02A9_5285; // four addresses, 3-state error
   localparam logic [5:0] AD [4] = '{6'h05, 6'h0A, 6'h15, 6'h2A};
   // two-way pins: the wire follows whoever drives it
   assign hold_pin_in = hold_pin_oe ? hold_pin_out : 1'b0;
   assign hold_or_strobe_pin_in = hold_or_strobe_pin_oe ? hold_or_strobe_pin_out : aoh_drv;
   bpo_port bpo_port_inst (.clk_sys, .nrst, .ce(1'b1), .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .force_zero_n, .pos_reset_n, .hold_pin_in,
      .hold_pin_out, .hold_pin_oe, .read_n, .port_select_address, .axis_clear_input_n,
      .hold_or_strobe_pin_in, .hold_or_strobe_pin_out, .hold_or_strobe_pin_oe, .pos_in,
      .cmp_high, .cmp_low, .err_status, .err_mask, .position_output_bus,
      .position_output_oe, .fast_output_bit, .error_pin_out, .error_pin_oe,
      .axis_fault_output, .axis_compare_output, .pos_load, .pos_load_preset);
   bpo_user_hw bpo_user_hw_inst (.clk_sys, .strobe(hold_or_strobe_pin_in),
      .bus(position_output_bus), .oe(position_output_oe), .lvl, .latched);
   initial forever #5 clk_sys = ~clk_sys;
   // link clock 125 ns, kept off the system edges
   initial #1 forever #62.5 aoh_drv = aoh_run ? ~aoh_drv : aoh_hi;
   task automatic wt(input int c);
      repeat (c) @(posedge clk_sys);
   endtask
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // apb master: hold request until pready seen at an edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      {rd, er} = {prdata, pslverr};
      {psel, penable} <= 2'b00;
   endtask
   task automatic t_regs;
      apb(1'b0, bpo_pkg::OFS_SETUP, 32'h0);
      chk(64'(rd), 64'h0);
      apb(1'b0, 12'h040, 32'h0);
      chk(64'(er), 64'h1);
      apb(1'b1, bpo_pkg::OFS_OUT_CTRL, OC);
   endtask
   task automatic t_read;
      read_n <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         port_select_address <= AD[i];
         wt(6);
         chk(64'(lvl), 64'(org[i]));
         chk(64'(error_pin_oe), 64'h1);
      end
      port_select_address <= 6'h3F;
      wt(6);
      chk(64'(position_output_oe), 64'h0);
      port_select_address <= AD[0];
      force_zero_n <= 1'b0;
      wt(6);
      chk(64'(lvl), 64'h0);
      {force_zero_n, read_n} <= 2'b11;
      wt(6);
      chk(64'(position_output_oe), 64'h0);
      chk(64'(error_pin_oe), 64'h0);
   endtask
   task automatic t_fault;
      err_status <= 32'h10;
      {read_n, port_select_address} <= {1'b0, AD[2]};
      wt(6);
      chk(64'(axis_fault_output), 64'h4);
      chk(64'(error_pin_out), 64'h1);
      port_select_address <= AD[0];
      wt(6);
      chk(64'(error_pin_out), 64'h0);
      {err_status, read_n} <= {32'h0, 1'b1};
      wt(4);
      chk(64'(axis_fault_output), 64'h0);
   endtask
   task automatic t_clear;
      apb(1'b1, bpo_pkg::OFS_SETUP, 32'h1100);
      axis_clear_input_n <= 4'hC;
      wt(6);
      chk(64'({pos_load, pos_load_preset}), 64'h11);
      {axis_clear_input_n, pos_reset_n} <= 5'h1E;
      wt(6);
      chk(64'(pos_load), 64'hF);
      pos_reset_n <= 1'b1;
   endtask
   task automatic t_fast;
      apb(1'b1, bpo_pkg::OFS_SETUP, 32'h10);
      read_n <= 1'b0;
      wt(25);
      for (int i = 0; i < 4; i++) fexp[i] = org[i][9:0];
      chk(64'(fast_output_bit), 64'(fexp));
      chk(64'(position_output_oe[35:10]), 64'h0);
      apb(1'b1, bpo_pkg::OFS_SETUP, 32'h0);
   endtask
   // async hold from the link clock, then held high while counters move
   task automatic t_async;
      apb(1'b1, bpo_pkg::OFS_OUT_CTRL, OC | 32'h0400_0000);
      aoh_run <= 1'b1;
      wt(40);
      {aoh_run, aoh_hi} <= 2'b01;
      wt(25);
      chk(64'(hold_pin_out), 64'h1);
      chk(64'(hold_pin_oe), 64'h1);
      pos_in[0] <= 36'h1_2345_6789;
      wt(30);
      chk(64'(lvl), 64'(org[0]));
      aoh_hi <= 1'b0;
   endtask
   task automatic t_divn;
      apb(1'b1, bpo_pkg::OFS_DIVN, 32'h3);
      apb(1'b1, bpo_pkg::OFS_OUT_CTRL, OC | 32'h0800_0000);
      wt(20);
      n = 0;
      repeat (400) begin
         @(posedge clk_sys);
         if (hold_pin_out === 1'b0) n++;
      end
      chk(64'(n), 64'd100);
   endtask
   task automatic t_strobe;
      apb(1'b1, bpo_pkg::OFS_OUT_CTRL, OC | 32'h0C00_0000);
      apb(1'b1, bpo_pkg::OFS_CMP, 32'h40);
      wt(40);
      chk(64'(latched), 64'h1_2345_6789);
      chk(64'(hold_or_strobe_pin_oe), 64'h1);
      chk(64'(axis_compare_output), 64'h8);
   endtask
   task automatic wrap_up;
      if (failures == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      for (int i = 0; i < 4; i++) pos_in[i] = {4'(i + 1), 32'hA5C3_0F00 | 32'(i)};
      org = pos_in;
      err_mask[2] = 32'h10;
      err_mask[0] = 32'h01;
      wt(16);
      nrst <= 1'b1;
      t_regs;
      t_read;
      t_fault;
      t_clear;
      t_fast;
      t_async;
      t_divn;
      t_strobe;
      wrap_up;
   end
   // watchdog well past the expected run length
   initial begin
      wt(8000);
      failures++;
      wrap_up;
   end
endmodule
